// ### logic/safe_mon_pkg.sv
package safe_mon_pkg;

	localparam int POS1_W = 24;
	localparam int POS2_W = 16;
	localparam int CRC_W = 16;
	localparam int SUM_W = 8;
	localparam int ST2_W = 8;
	localparam int EV_W = 8;

	localparam logic [SUM_W-1:0] SUM_CRIT_MASK = 8'h07;
	localparam logic [SUM_W-1:0] SUM_CAP_MASK = 8'h08;
	localparam int TOG_BIT = 0;
	localparam logic [ST2_W-1:0] CH2_CRIT_DEF = 8'hFE;
	localparam logic [CRC_W-1:0] CRC_POLY_DEF = 16'h1021;
	localparam logic [CRC_W-1:0] CRC_INIT = 16'h0000;
	localparam logic [15:0] DEV_RESET = 16'h0002;
	localparam logic [1:0] CTRL_RESET = 2'h0;

	localparam int RESP_TIME_US = 216;
	localparam int CLK_PERIOD_NS = 10;
	localparam int RESP_CYC = (RESP_TIME_US * 1000) / CLK_PERIOD_NS;

	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_DEV = 8'h04;
	localparam logic [7:0] ADDR_STAT = 8'h08;
	localparam logic [7:0] ADDR_CLR = 8'h0C;
	localparam logic [7:0] ADDR_EN = 8'h10;
	localparam logic [7:0] ADDR_POS = 8'h14;

	localparam int CTRL_EN = 0;
	localparam int CTRL_CAP = 1;

	localparam int EV_SUM = 0;
	localparam int EV_CH2 = 1;
	localparam int EV_STUCK = 2;
	localparam int EV_XCHK = 3;
	localparam int EV_CRC1 = 4;
	localparam int EV_CRC2 = 5;
	localparam int EV_TMO = 6;
	localparam int EV_WARN = 7;
	localparam logic [EV_W-1:0] SAFE_MASK = 8'h7F;

	typedef struct packed {
		logic [POS1_W-1:0] pos;
		logic [CRC_W-1:0] crc;
		logic [SUM_W-1:0] sum;
	} ch1_sample_t;

	typedef struct packed {
		logic [POS2_W-1:0] pos;
		logic [CRC_W-1:0] crc;
		logic [ST2_W-1:0] status;
	} ch2_sample_t;

	typedef enum logic {
		PH_ADDR = 1'b0,
		PH_DATA = 1'b1
	} bus_phase_t;

	// MSB-first CRC over the top n bits of d
	function automatic logic [CRC_W-1:0] crc_calc(
		input logic [POS1_W-1:0] d,
		input int n,
		input logic [CRC_W-1:0] poly);
		logic [CRC_W-1:0] c;
		logic fb;
		c = CRC_INIT;
		fb = 1'b0;
		for (int i = 0; i < POS1_W; i++) begin
			if (i < n) begin
				fb = c[CRC_W-1] ^ d[POS1_W-1-i];
				c = {c[CRC_W-2:0], 1'b0} ^ (fb ? poly : CRC_INIT);
			end
		end
		return c;
	endfunction

endpackage

// ### logic/safe_position_monitor.sv
`timescale 1ns/1ps
module safe_position_monitor
	import safe_mon_pkg::*;
#(
	parameter int RESP_CYCLES = RESP_CYC,
	parameter logic [ST2_W-1:0] CH2_CRIT_MASK = CH2_CRIT_DEF,
	parameter logic [CRC_W-1:0] CRC_POLY = CRC_POLY_DEF
) (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic o_hreadyout,
	output logic o_hresp,
	output logic [31:0] o_hrdata,
	input wire logic i_ch1_valid,
	input wire ch1_sample_t i_ch1,
	input wire logic i_ch2_valid,
	input wire ch2_sample_t i_ch2,
	output logic o_safe_state,
	output logic o_irq
);

	generate
		if (RESP_CYCLES < 2 || RESP_CYCLES > 16777215) begin : g_bad_resp
			$error("RESP_CYCLES out of range");
		end
		if (POS2_W > POS1_W) begin : g_bad_width
			$error("channel two wider than channel one");
		end
	endgenerate

	// ------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------
	bus_phase_t phase_reg, phase_next;
	logic [7:0] addr_reg, addr_next;
	logic write_reg, write_next;
	logic hready_reg, hready_next;
	logic [31:0] rdata_reg, rdata_next;
	logic hresp_reg;
	logic [1:0] ctrl_reg, ctrl_next;
	logic [15:0] dev_reg, dev_next;
	logic [EV_W-1:0] en_reg, en_next;
	logic [EV_W-1:0] clr;
	logic [EV_W-1:0] status_reg;
	logic [15:0] last1_reg;
	logic [15:0] last2_reg;

	// Every transfer gets one wait state so read data leaves a flop
	always_comb begin
		phase_next = phase_reg;
		addr_next = addr_reg;
		write_next = write_reg;
		hready_next = hready_reg;
		rdata_next = rdata_reg;
		ctrl_next = ctrl_reg;
		dev_next = dev_reg;
		en_next = en_reg;
		clr = '0;
		unique case (phase_reg)
			PH_ADDR: begin
				if (i_hsel && i_htrans[1] && i_hready) begin
					phase_next = PH_DATA;
					addr_next = i_haddr[7:0];
					write_next = i_hwrite;
					hready_next = 1'b0;
				end
			end
			PH_DATA: begin
				phase_next = PH_ADDR;
				hready_next = 1'b1;
				rdata_next = 32'h00000000;
				if (write_reg) begin
					unique case (addr_reg)
						ADDR_CTRL: ctrl_next = i_hwdata[1:0];
						ADDR_DEV: dev_next = i_hwdata[15:0];
						ADDR_CLR: clr = i_hwdata[EV_W-1:0];
						ADDR_EN: en_next = i_hwdata[EV_W-1:0];
						default: ;
					endcase
				end else begin
					unique case (addr_reg)
						ADDR_CTRL: rdata_next = {30'h0, ctrl_reg};
						ADDR_DEV: rdata_next = {16'h0, dev_reg};
						ADDR_STAT: rdata_next = {24'h0, status_reg};
						ADDR_EN: rdata_next = {24'h0, en_reg};
						ADDR_POS: rdata_next = {last1_reg, last2_reg};
						default: rdata_next = 32'h00000000;
					endcase
				end
			end
		endcase
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			phase_reg <= PH_ADDR;
			addr_reg <= 8'h00;
			write_reg <= 1'b0;
			hready_reg <= 1'b1;
			rdata_reg <= 32'h00000000;
			hresp_reg <= 1'b0;
			ctrl_reg <= CTRL_RESET;
			dev_reg <= DEV_RESET;
			en_reg <= 8'h00;
		end else begin
			phase_reg <= phase_next;
			addr_reg <= addr_next;
			write_reg <= write_next;
			hready_reg <= hready_next;
			rdata_reg <= rdata_next;
			hresp_reg <= 1'b0;
			ctrl_reg <= ctrl_next;
			dev_reg <= dev_next;
			en_reg <= en_next;
		end
	end

	assign o_hreadyout = hready_reg;
	assign o_hresp = hresp_reg;
	assign o_hrdata = rdata_reg;

	// ------------------------------------------------------------
	// Safe channel checks
	// ------------------------------------------------------------
	ch1_sample_t s1_reg, s1_next;
	ch2_sample_t s2_reg, s2_next;
	logic have1_reg, have1_next;
	logic have2_reg, have2_next;
	logic tog_prev_reg, tog_prev_next;
	logic tog_ok_reg, tog_ok_next;
	logic [23:0] tmr_reg, tmr_next;
	logic [EV_W-1:0] status_next;
	logic [15:0] last1_next, last2_next;
	logic safe_reg, safe_next;
	logic irq_reg, irq_next;
	logic [EV_W-1:0] ev;
	logic [SUM_W-1:0] crit1;
	logic [POS2_W-1:0] p1_top, p2_true, diff, mag;
	logic pair;

	always_comb begin
		ev = '0;
		s1_next = s1_reg;
		s2_next = s2_reg;
		have1_next = have1_reg;
		have2_next = have2_reg;
		tog_prev_next = tog_prev_reg;
		tog_ok_next = tog_ok_reg;
		last1_next = last1_reg;
		last2_next = last2_reg;
		pair = have1_reg && have2_reg;
		p1_top = s1_reg.pos[POS1_W-1 -: POS2_W];
		p2_true = ~s2_reg.pos;
		diff = p1_top - p2_true;
		// Modulo difference handles wrap at the turn boundary
		mag = diff[POS2_W-1] ? POS2_W'(-diff) : diff;
		crit1 = SUM_CRIT_MASK;
		if (ctrl_reg[CTRL_CAP]) begin
			crit1 = SUM_CRIT_MASK | SUM_CAP_MASK;
		end
		if (pair) begin
			have1_next = 1'b0;
			have2_next = 1'b0;
			last1_next = p1_top;
			last2_next = p2_true;
			if (mag > dev_reg) begin
				ev[EV_XCHK] = 1'b1;
			end
		end
		if (i_ch1_valid) begin
			s1_next = i_ch1;
			have1_next = 1'b1;
			if (|(i_ch1.sum & crit1)) begin
				ev[EV_SUM] = 1'b1;
			end
			// Nonzero outside the critical set is only a warning
			if (|(i_ch1.sum & ~crit1)) begin
				ev[EV_WARN] = 1'b1;
			end
			if (crc_calc(i_ch1.pos, POS1_W, CRC_POLY) != i_ch1.crc) begin
				ev[EV_CRC1] = 1'b1;
			end
		end
		if (i_ch2_valid) begin
			s2_next = i_ch2;
			have2_next = 1'b1;
			if (|(i_ch2.status & CH2_CRIT_MASK)) begin
				ev[EV_CH2] = 1'b1;
			end
			if (tog_ok_reg && i_ch2.status[TOG_BIT] == tog_prev_reg) begin
				ev[EV_STUCK] = 1'b1;
			end
			tog_prev_next = i_ch2.status[TOG_BIT];
			tog_ok_next = 1'b1;
			// Checksum covers the value as transmitted, still inverted
			if (crc_calc({i_ch2.pos, {(POS1_W-POS2_W){1'b0}}}, POS2_W,
				CRC_POLY) != i_ch2.crc) begin
				ev[EV_CRC2] = 1'b1;
			end
		end
		// A pair must complete within the delivery window
		tmr_next = tmr_reg + 24'h000001;
		if (!ctrl_reg[CTRL_EN] || pair) begin
			tmr_next = 24'h000000;
		end else if (tmr_reg == 24'(RESP_CYCLES - 1)) begin
			ev[EV_TMO] = 1'b1;
			tmr_next = 24'h000000;
		end
		// New events win over a clear in the same cycle
		status_next = (status_reg & ~clr) | ev;
		safe_next = |(status_next & SAFE_MASK);
		irq_next = |(status_next & en_reg);
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			s1_reg <= '0;
			s2_reg <= '0;
			have1_reg <= 1'b0;
			have2_reg <= 1'b0;
			tog_prev_reg <= 1'b0;
			tog_ok_reg <= 1'b0;
			tmr_reg <= 24'h000000;
			status_reg <= 8'h00;
			last1_reg <= 16'h0000;
			last2_reg <= 16'h0000;
			safe_reg <= 1'b0;
			irq_reg <= 1'b0;
		end else begin
			s1_reg <= s1_next;
			s2_reg <= s2_next;
			have1_reg <= have1_next;
			have2_reg <= have2_next;
			tog_prev_reg <= tog_prev_next;
			tog_ok_reg <= tog_ok_next;
			tmr_reg <= tmr_next;
			status_reg <= status_next;
			last1_reg <= last1_next;
			last2_reg <= last2_next;
			safe_reg <= safe_next;
			irq_reg <= irq_next;
		end
	end

	assign o_safe_state = safe_reg;
	assign o_irq = irq_reg;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	// A clear may follow at once, so safe state is checked with the flag
	AST_SUM_CRIT: assert property (
		@(posedge i_sys_clk) disable iff (i_rst)
		i_ch1_valid && |i_ch1.sum[2:0] |=> status_reg[EV_SUM] && o_safe_state)
		else $error("critical summary not flagged");
	AST_SUM_CAP: assert property (
		@(posedge i_sys_clk) disable iff (i_rst)
		i_ch1_valid && ctrl_reg[CTRL_CAP] && i_ch1.sum[3] |=> status_reg[EV_SUM])
		else $error("capacitive summary bit not flagged");
	AST_WARN: assert property (
		@(posedge i_sys_clk) disable iff (i_rst)
		i_ch1_valid && |i_ch1.sum[7:4] |=> status_reg[EV_WARN])
		else $error("summary warning not flagged");
	AST_CH2_STAT: assert property (
		@(posedge i_sys_clk) disable iff (i_rst)
		i_ch2_valid && |(i_ch2.status & CH2_CRIT_MASK) |=> status_reg[EV_CH2])
		else $error("channel two status not flagged");
	// Samples may be far apart, so compare with the stored toggle value
	AST_STUCK: assert property (
		@(posedge i_sys_clk) disable iff (i_rst)
		i_ch2_valid && tog_ok_reg && i_ch2.status[TOG_BIT] == tog_prev_reg
		|=> status_reg[EV_STUCK])
		else $error("stuck toggle not flagged");
	AST_XCHK: assert property (
		@(posedge i_sys_clk) disable iff (i_rst)
		pair && mag > dev_reg
		|=> status_reg[EV_XCHK] && last1_reg == $past(p1_top))
		else $error("cross-check error not flagged");
	AST_XCHK_OK: assert property (
		@(posedge i_sys_clk) disable iff (i_rst)
		pair && mag <= dev_reg && !status_reg[EV_XCHK] && clr == '0
		|=> !status_reg[EV_XCHK])
		else $error("spurious cross-check error");
	AST_CRC1: assert property (
		@(posedge i_sys_clk) disable iff (i_rst)
		i_ch1_valid && crc_calc(i_ch1.pos, POS1_W, CRC_POLY) != i_ch1.crc
		|=> status_reg[EV_CRC1] && o_safe_state)
		else $error("channel one checksum error missed");
	AST_CRC2: assert property (
		@(posedge i_sys_clk) disable iff (i_rst)
		i_ch2_valid && crc_calc({i_ch2.pos, {(POS1_W-POS2_W){1'b0}}}, POS2_W,
		CRC_POLY) != i_ch2.crc |=> status_reg[EV_CRC2] && o_safe_state)
		else $error("channel two checksum error missed");
	AST_SAFE: assert property (
		@(posedge i_sys_clk) disable iff (i_rst)
		o_safe_state == |(status_reg & SAFE_MASK))
		else $error("safe state disagrees with status");
	AST_TMO: assert property (
		@(posedge i_sys_clk) disable iff (i_rst)
		ctrl_reg[CTRL_EN] && !pair && tmr_reg == 24'(RESP_CYCLES - 1)
		|=> status_reg[EV_TMO] && tmr_reg == 24'h000000)
		else $error("delivery timeout missed");

endmodule // safe_position_monitor

// ### test/enc_safe_source.sv
`timescale 1ns/1ps
module enc_safe_source
	import safe_mon_pkg::*;
(
	input wire logic i_sys_clk,
	output logic o_ch1_valid,
	output ch1_sample_t o_ch1,
	output logic o_ch2_valid,
	output ch2_sample_t o_ch2
);
	logic tog;
	initial begin
		tog = 1'h0;
		o_ch1_valid = 1'h0;
		o_ch2_valid = 1'h0;
		o_ch1 = '0;
		o_ch2 = '0;
	end
	function automatic logic [15:0] crc(input logic [23:0] d, input int n);
		logic [15:0] c;
		c = 16'h0000;
		for (int i = n - 1; i >= 0; i--)
			c = {c[14:0], 1'h0} ^ ((c[15] ^ d[i]) ? CRC_POLY_DEF : 16'h0000);
		return c;
	endfunction
	// Bad: [0] ch1 checksum, [1] ch2 checksum, [2] hold toggle
	task automatic send(input logic [23:0] p1, input logic [15:0] p2,
		input logic [7:0] sum, input logic [7:0] st, input logic [2:0] bad);
		logic [15:0] q;
		q = ~p2;
		@(posedge i_sys_clk);
		if (!bad[2])
			tog = ~tog;
		o_ch1_valid <= 1'h1;
		o_ch2_valid <= 1'h1;
		o_ch1 <= {p1, crc(p1, 24) ^ {15'h0000, bad[0]}, sum};
		o_ch2 <= {q, crc({8'h00, q}, 16) ^ {15'h0000, bad[1]}, st[7:1], tog};
		@(posedge i_sys_clk);
		o_ch1_valid <= 1'h0;
		o_ch2_valid <= 1'h0;
		// Released lines must not keep a stale copy of the sample
		o_ch1 <= ~o_ch1;
		o_ch2 <= ~o_ch2;
	endtask
endmodule // enc_safe_source

// ### test/testbench.sv
`timescale 1ns/1ps
module testbench
	import safe_mon_pkg::*;
;
	logic clk, rst, hsel, hwrite, hready, hresp, safe, irq, v1, v2, rd_phase;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata;
	logic [7:0] en;
	ch1_sample_t ch1;
	ch2_sample_t ch2;
	logic [31:0] exp_q[$];
	int n_errors, samples_checked;

	safe_position_monitor #(.RESP_CYCLES(50)) dut (
		.i_sys_clk(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
		.i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hready),
		.o_hresp(hresp), .o_hrdata(hrdata), .i_ch1_valid(v1), .i_ch1(ch1),
		.i_ch2_valid(v2), .i_ch2(ch2), .o_safe_state(safe), .o_irq(irq));
	enc_safe_source src (.i_sys_clk(clk), .o_ch1_valid(v1), .o_ch1(ch1),
		.o_ch2_valid(v2), .o_ch2(ch2));

	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic conclude();
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic bus(input logic [7:0] a, input logic w,
		input logic [31:0] d, input logic [31:0] e);
		if (!w)
			exp_q.push_back(e);
		hsel <= 1'h1;
		htrans <= 2'h2;
		haddr <= {24'h000000, a};
		hwrite <= w;
		do @(posedge clk); while (!hready);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (!hready);
	endtask
	task automatic stat(input logic [7:0] e);
		bus(ADDR_STAT, 1'h0, 32'h0, {24'h0, e});
		chk("safe_state", 32'(|(e & SAFE_MASK)), 32'(safe));
		chk("irq", 32'(|(e & en)), 32'(irq));
		bus(ADDR_CLR, 1'h1, 32'hFF, 32'h0);
	endtask
	task automatic pair(input logic [15:0] dt, input logic [7:0] sum,
		input logic [7:0] st, input logic [2:0] bad, input logic [7:0] e);
		logic [23:0] p1;
		p1 = 24'($urandom);
		src.send(p1, p1[23:8] + dt, sum, st, bad);
		repeat (3) @(posedge clk);
		if (e == 8'h00)
			bus(ADDR_POS, 1'h0, 32'h0, {p1[23:8], 16'(p1[23:8] + dt)});
		stat(e);
	endtask

	// Monitor: a read completes when hready returns high
	always @(posedge clk) begin
		if (rd_phase && hready)
			chk("hrdata", exp_q.pop_front(), hrdata);
		if (hready)
			rd_phase <= hsel && htrans[1] && !hwrite;
	end

	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		conclude();
	end
	initial begin
		void'($urandom(11));
		{rst, hsel, hwrite, htrans, haddr, hwdata, en, rd_phase} = '0;
		rst = 1'h1;
		repeat (10) @(posedge clk);
		rst <= 1'h0;
		bus(ADDR_CTRL, 1'h0, 32'h0, 32'h0);
		bus(ADDR_DEV, 1'h0, 32'h0, 32'h2);
		bus(ADDR_STAT, 1'h0, 32'h0, 32'h0);
		bus(8'h20, 1'h0, 32'h0, 32'h0);
		bus(ADDR_CLR, 1'h0, 32'h0, 32'h0);
		chk("hresp", 32'h0, 32'(hresp));
		pair(16'h0, 8'h00, 8'h00, 3'h0, 8'h00);
		pair(16'h2, 8'h00, 8'h00, 3'h0, 8'h00);
		pair(16'h3, 8'h00, 8'h00, 3'h0, 8'h08);
		pair(16'hFFFD, 8'h00, 8'h00, 3'h0, 8'h08);
		bus(ADDR_DEV, 1'h1, 32'h3, 32'h0);
		pair(16'h3, 8'h00, 8'h00, 3'h0, 8'h00);
		bus(ADDR_DEV, 1'h1, 32'h2, 32'h0);
		for (int i = 0; i < 8; i++)
			pair(16'h0, 8'(8'h01 << i), 8'h00, 3'h0, i < 3 ? 8'h01 : 8'h80);
		bus(ADDR_CTRL, 1'h1, 32'h2, 32'h0);
		pair(16'h0, 8'h08, 8'h00, 3'h0, 8'h01);
		bus(ADDR_CTRL, 1'h1, 32'h0, 32'h0);
		for (int i = 1; i < 8; i++)
			pair(16'h0, 8'h00, 8'(8'h01 << i), 3'h0, 8'h02);
		pair(16'h0, 8'h00, 8'h00, 3'h4, 8'h04);
		pair(16'h0, 8'h00, 8'h00, 3'h1, 8'h10);
		pair(16'h0, 8'h00, 8'h00, 3'h2, 8'h20);
		en = 8'h08;
		bus(ADDR_EN, 1'h1, 32'h8, 32'h0);
		pair(16'h5, 8'h00, 8'h00, 3'h0, 8'h08);
		en = 8'h00;
		bus(ADDR_EN, 1'h1, 32'h0, 32'h0);
		pair(16'h5, 8'h00, 8'h00, 3'h0, 8'h08);
		// Delivery watchdog: no pair for longer than RESP_CYCLES
		bus(ADDR_CTRL, 1'h1, 32'h1, 32'h0);
		repeat (60) @(posedge clk);
		bus(ADDR_CTRL, 1'h1, 32'h0, 32'h0);
		stat(8'h40);
		repeat (5) @(posedge clk);
		conclude();
	end
endmodule // testbench
